//--- cbr_params.svh
`ifndef CBR_PARAMS_SVH
`define CBR_PARAMS_SVH

// ****************************************************************
// Clock
// ****************************************************************
`define CBR_SYS_CLK_HZ      25000000

// ****************************************************************
// Register offsets
// ****************************************************************
`define CBR_OFS_FIRMWARE    8'h97
`define CBR_OFS_CONTROL     8'h98
`define CBR_OFS_STATUS      8'h99

// ****************************************************************
// Control fields
// ****************************************************************
`define CBR_CTRL_PAGE       0
`define CBR_CTRL_AUTO_RST   1
`define CBR_CTRL_HOLD_RST   2
`define CBR_CTRL_RESTART    8

// ****************************************************************
// Status fields
// ****************************************************************
`define CBR_STAT_RD_BUSY    0
`define CBR_STAT_WR_BUSY    1

// ****************************************************************
// Reset values and identity
// ****************************************************************
`define CBR_CTRL_RESET      16'h0000
`define CBR_STAT_RESET      16'h0000
`define CBR_FIRMWARE_ID     16'h0105
`define CBR_I2C_DEV_ADDR    7'h48

// ****************************************************************
// Timing
// ****************************************************************
`define CBR_SENS_OFF_MS     100
`define CBR_RESTART_MS      100
`define CBR_PWR_SETTLE_US   1
// Cycles per millisecond are formed first so that the product stays inside 32 bits.
`define CBR_SENS_OFF_CYC    (`CBR_SENS_OFF_MS * (`CBR_SYS_CLK_HZ / 1000))
`define CBR_RESTART_CYC     (`CBR_RESTART_MS * (`CBR_SYS_CLK_HZ / 1000))
`define CBR_PWR_SETTLE_CYC  ((`CBR_PWR_SETTLE_US * `CBR_SYS_CLK_HZ + 999999) / 1000000)
`define CBR_ROI_MAX_GLOBAL  4'h8
`define CBR_ROI_MAX_ROLLING 4'h1

`endif

//--- cbr_pkg.sv
package cbr_pkg;

  // Power sequencer of the image sensor.
  typedef enum logic [4:0] {
    PWR_ON     = 5'b00001,
    PWR_TIMED  = 5'b00010,
    PWR_HELD   = 5'b00100,
    PWR_SETTLE = 5'b01000,
    PWR_RESTART = 5'b10000
  } cbr_pwr_state_t;

  // Byte engine of the two-wire slave.
  typedef enum logic [5:0] {
    I2C_IDLE = 6'b000001,
    I2C_RX   = 6'b000010,
    I2C_ACK  = 6'b000100,
    I2C_WAIT = 6'b001000,
    I2C_TX   = 6'b010000,
    I2C_RACK = 6'b100000
  } cbr_i2c_state_t;

endpackage

//--- cbr_reg_if.sv
`timescale 1ns/10ps

interface cbr_reg_if;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rd_ready;

  modport link (output wr, rd, addr, wdata, input rdata, rd_ready);
  modport regs (input wr, rd, addr, wdata, output rdata, rd_ready);
endinterface

//--- cbr_i2c_slave.sv
`timescale 1ns/10ps
`include "cbr_params.svh"

module cbr_i2c_slave
  import cbr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `CBR_I2C_DEV_ADDR
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  // Two-wire pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_oe,
  output logic      o_sda_oe,
  // Register side
  cbr_reg_if.link   bus
);

  cbr_i2c_state_t state_reg;
  logic           scl_q;
  logic           sda_q;
  logic [3:0]     bitc_reg;
  logic [1:0]     byte_reg;
  logic [7:0]     shift_reg;
  logic [7:0]     lsb_reg;
  logic           rw_reg;
  logic           ack_ok_reg;
  logic           wr_reg;
  logic           rd_reg;
  logic [7:0]     addr_reg;
  logic [15:0]    wdata_reg;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_seen;
  logic           stop_seen;

  assign scl_rise   = i_scl & ~scl_q;
  assign scl_fall   = ~i_scl & scl_q;
  assign start_seen = scl_q & i_scl & sda_q & ~i_sda;
  assign stop_seen  = scl_q & i_scl & ~sda_q & i_sda;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // ****************************************************************
  // Byte engine
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg  <= I2C_IDLE;
      bitc_reg   <= 4'h0;
      byte_reg   <= 2'h0;
      shift_reg  <= 8'h00;
      lsb_reg    <= 8'h00;
      rw_reg     <= 1'b0;
      ack_ok_reg <= 1'b0;
      wr_reg     <= 1'b0;
      rd_reg     <= 1'b0;
      addr_reg   <= 8'h00;
      wdata_reg  <= 16'h0000;
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      if (start_seen) begin
        state_reg <= I2C_RX;
        bitc_reg  <= 4'h0;
        byte_reg  <= 2'h0;
      end else if (stop_seen) begin
        state_reg <= I2C_IDLE;
      end else begin
        unique case (state_reg)
          I2C_IDLE: begin
          end
          I2C_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], i_sda};
              bitc_reg  <= bitc_reg + 4'h1;
            end else if (scl_fall && bitc_reg == 4'h8) begin
              bitc_reg  <= 4'h0;
              state_reg <= I2C_ACK;
              unique case (byte_reg)
                2'h0: begin
                  if (shift_reg[7:1] != DEV_ADDR) begin
                    state_reg <= I2C_IDLE;
                  end
                  rw_reg <= shift_reg[0];
                end
                2'h1: addr_reg <= shift_reg;
                2'h2: wdata_reg[15:8] <= shift_reg;
                2'h3: begin
                  wdata_reg[7:0] <= shift_reg;
                  wr_reg         <= 1'b1;
                end
              endcase
            end
          end
          I2C_ACK: begin
            if (scl_fall) begin
              if (rw_reg && byte_reg == 2'h0) begin
                rd_reg    <= 1'b1;
                state_reg <= I2C_WAIT;
              end else if (byte_reg == 2'h3) begin
                state_reg <= I2C_IDLE;
              end else begin
                state_reg <= I2C_RX;
                byte_reg  <= byte_reg + 2'h1;
              end
            end
          end
          I2C_WAIT: begin
            if (bus.rd_ready) begin
              shift_reg <= bus.rdata[15:8];
              lsb_reg   <= bus.rdata[7:0];
              bitc_reg  <= 4'h0;
              byte_reg  <= 2'h0;
              state_reg <= I2C_TX;
            end
          end
          I2C_TX: begin
            if (scl_fall) begin
              if (bitc_reg == 4'h7) begin
                state_reg <= I2C_RACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                bitc_reg  <= bitc_reg + 4'h1;
              end
            end
          end
          I2C_RACK: begin
            if (scl_rise) begin
              ack_ok_reg <= ~i_sda;
            end else if (scl_fall) begin
              if (ack_ok_reg && byte_reg == 2'h0) begin
                shift_reg <= lsb_reg;
                bitc_reg  <= 4'h0;
                byte_reg  <= 2'h1;
                state_reg <= I2C_TX;
              end else begin
                state_reg <= I2C_IDLE;
              end
            end
          end
          default: state_reg <= I2C_IDLE;
        endcase
      end
    end
  end

  assign o_scl_oe  = (state_reg == I2C_WAIT);
  assign o_sda_oe  = (state_reg == I2C_ACK) | ((state_reg == I2C_TX) & ~shift_reg[7]);
  assign bus.wr    = wr_reg;
  assign bus.rd    = rd_reg;
  assign bus.addr  = addr_reg;
  assign bus.wdata = wdata_reg;

endmodule

//--- cbr_ctrl_status.sv
`timescale 1ns/10ps
`include "cbr_params.svh"

module cbr_ctrl_status
  import cbr_pkg::*;
#(
  parameter int unsigned SENS_OFF_CYC = `CBR_SENS_OFF_CYC,
  parameter int unsigned RESTART_CYC  = `CBR_RESTART_CYC,
  parameter logic [15:0] FIRMWARE_ID  = `CBR_FIRMWARE_ID  // Value is arbitrary.
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // Two-wire host link, open drain
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oe,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe,
  // Sensor register access
  output logic             o_sens_req,
  output logic             o_sens_we,
  output logic [8:0]       o_sens_addr,
  output logic [15:0]      o_sens_wdata,
  input  wire logic        i_sens_done,
  input  wire logic [15:0] i_sens_rdata,
  // Sensor power and reset
  output logic             o_sens_pwr_en,
  output logic             o_sens_rst_b,
  output logic             o_module_restart,
  // Window configuration
  input  wire logic        i_global_shutter,
  output logic [3:0]       o_roi_max
);

  localparam logic [21:0] SETTLE_CYC = 22'(`CBR_PWR_SETTLE_CYC);
  cbr_reg_if bus ();

  cbr_pwr_state_t pwr_reg;
  logic [21:0]    timer_reg;
  logic           page_reg;
  logic           auto_reg;
  logic           hold_reg;
  logic           restart_reg;
  logic           rd_busy_reg;
  logic           wr_busy_reg;
  logic           pend_reg;
  logic           we_reg;
  logic [8:0]     saddr_reg;
  logic [15:0]    swdata_reg;
  logic [15:0]    rdata_reg;
  logic           rd_ready_reg;
  logic           roi_max_reg;
  logic           is_local;
  logic           ctrl_wr;
  logic           restart_done;
  logic           settle_done;
  logic           sens_on;
  logic           sens_ack;
  logic [15:0]    ctrl_view;
  logic [15:0]    stat_view;

  cbr_i2c_slave u_i2c (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_scl_oe  (o_scl_oe),
    .o_sda_oe  (o_sda_oe),
    .bus       (bus.link)
  );

  assign is_local     = (bus.addr == `CBR_OFS_FIRMWARE) | (bus.addr == `CBR_OFS_CONTROL) |
                        (bus.addr == `CBR_OFS_STATUS);
  assign ctrl_wr      = bus.wr & (bus.addr == `CBR_OFS_CONTROL) & (pwr_reg != PWR_RESTART);
  assign restart_done = (pwr_reg == PWR_RESTART) & (timer_reg == 22'h000001);
  assign settle_done  = (pwr_reg == PWR_SETTLE) & (timer_reg == 22'h000001);
  assign sens_on      = (pwr_reg == PWR_ON);
  assign sens_ack     = pend_reg & sens_on & i_sens_done;

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      page_reg <= 1'b0;
    end else if (restart_done) begin
      page_reg <= 1'b0;
    end else if (ctrl_wr) begin
      page_reg <= bus.wdata[`CBR_CTRL_PAGE];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      auto_reg <= 1'b0;
    end else if (restart_done) begin
      auto_reg <= 1'b0;
    end else if (ctrl_wr && bus.wdata[`CBR_CTRL_AUTO_RST]) begin
      auto_reg <= 1'b1;
    end else if (settle_done && !hold_reg) begin
      auto_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_reg <= 1'b0;
    end else if (restart_done) begin
      hold_reg <= 1'b0;
    end else if (ctrl_wr) begin
      hold_reg <= bus.wdata[`CBR_CTRL_HOLD_RST];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      restart_reg <= 1'b0;
    end else if (restart_done) begin
      restart_reg <= 1'b0;
    end else if (ctrl_wr && bus.wdata[`CBR_CTRL_RESTART]) begin
      restart_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Sensor power sequencer
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_reg   <= PWR_ON;
      timer_reg <= 22'h000000;
    end else if (restart_reg && pwr_reg != PWR_RESTART) begin
      pwr_reg   <= PWR_RESTART;
      timer_reg <= RESTART_CYC[21:0];
    end else begin
      unique case (pwr_reg)
        PWR_ON: begin
          if (hold_reg) begin
            pwr_reg <= PWR_HELD;
          end else if (auto_reg) begin
            pwr_reg   <= PWR_TIMED;
            timer_reg <= SENS_OFF_CYC[21:0];
          end
        end
        PWR_TIMED, PWR_SETTLE, PWR_RESTART: begin
          if (timer_reg != 22'h000001) begin
            timer_reg <= timer_reg - 22'h000001;
          end else if (pwr_reg == PWR_SETTLE) begin
            pwr_reg <= PWR_ON;
          end else begin
            pwr_reg   <= PWR_SETTLE;
            timer_reg <= SETTLE_CYC;
          end
        end
        PWR_HELD: begin
          if (!hold_reg) begin
            pwr_reg   <= PWR_SETTLE;
            timer_reg <= SETTLE_CYC;
          end
        end
        default: pwr_reg <= PWR_ON;
      endcase
    end
  end

  // ****************************************************************
  // Sensor access and busy flags
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_reg   <= 1'b0;
      we_reg     <= 1'b0;
      saddr_reg  <= 9'h000;
      swdata_reg <= 16'h0000;
    end else if (restart_done) begin
      pend_reg <= 1'b0;
    end else if ((bus.wr || bus.rd) && !is_local) begin
      pend_reg   <= 1'b1;
      we_reg     <= bus.wr;
      saddr_reg  <= {page_reg, bus.addr};
      swdata_reg <= bus.wdata;
    end else if (sens_ack) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_busy_reg <= 1'b0;
      rd_busy_reg <= 1'b0;
    end else if (restart_done) begin
      wr_busy_reg <= 1'b0;
      rd_busy_reg <= 1'b0;
    end else begin
      if (bus.wr && !is_local) begin
        wr_busy_reg <= 1'b1;
      end else if (sens_ack && we_reg) begin
        wr_busy_reg <= 1'b0;
      end
      if (bus.rd && !is_local) begin
        rd_busy_reg <= 1'b1;
      end else if (sens_ack && !we_reg) begin
        rd_busy_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read answer
  // ****************************************************************
  assign ctrl_view = {7'h00, restart_reg, 5'h00, hold_reg, auto_reg, page_reg};
  assign stat_view = {14'h0000, wr_busy_reg, rd_busy_reg};

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg    <= 16'h0000;
      rd_ready_reg <= 1'b0;
    end else begin
      rd_ready_reg <= 1'b0;
      if (bus.rd && is_local) begin
        rd_ready_reg <= 1'b1;
        if (bus.addr == `CBR_OFS_FIRMWARE) begin
          rdata_reg <= FIRMWARE_ID;
        end else if (bus.addr == `CBR_OFS_CONTROL) begin
          rdata_reg <= ctrl_view;
        end else begin
          rdata_reg <= stat_view;
        end
      end else if (sens_ack && !we_reg) begin
        rd_ready_reg <= 1'b1;
        rdata_reg    <= i_sens_rdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      roi_max_reg <= 1'b0;
    end else begin
      roi_max_reg <= i_global_shutter;
    end
  end

  assign o_roi_max = roi_max_reg ? `CBR_ROI_MAX_GLOBAL : `CBR_ROI_MAX_ROLLING;

  assign bus.rdata        = rdata_reg;
  assign bus.rd_ready     = rd_ready_reg;
  assign o_scl            = 1'b0;
  assign o_sda            = 1'b0;
  assign o_sens_req       = pend_reg & sens_on;
  assign o_sens_we        = we_reg;
  assign o_sens_addr      = saddr_reg;
  assign o_sens_wdata     = swdata_reg;
  assign o_sens_pwr_en    = (pwr_reg == PWR_ON) | (pwr_reg == PWR_SETTLE);
  assign o_sens_rst_b     = sens_on;
  assign o_module_restart = (pwr_reg == PWR_RESTART);

endmodule

//--- cbr_ctrl_status_monitor.sv
`timescale 1ns/10ps

// ****************************************************************
// Port checker
// ****************************************************************
module cbr_ctrl_status_monitor #(
  parameter int unsigned SENS_OFF_CYC = 20
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        o_scl_oe,
  input wire logic        o_sens_req,
  input wire logic        o_sens_we,
  input wire logic [8:0]  o_sens_addr,
  input wire logic [15:0] o_sens_wdata,
  input wire logic        i_sens_done,
  input wire logic        o_sens_pwr_en,
  input wire logic        o_sens_rst_b,
  input wire logic        o_module_restart,
  input wire logic        i_global_shutter,
  input wire logic [3:0]  o_roi_max
);
  logic [31:0] off_cnt_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      off_cnt_reg <= '0;
    end else if (!o_sens_pwr_en) begin
      off_cnt_reg <= off_cnt_reg + 32'h1;
    end else begin
      off_cnt_reg <= '0;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_settle;
    (o_sens_pwr_en && !o_sens_rst_b) [*8];
  endsequence
  sequence s_release;
    ##[1:40] $rose(o_sens_rst_b);
  endsequence

  a_req_powered: assert property (o_sens_req |-> o_sens_pwr_en && o_sens_rst_b)
    else $error("sensor request while sensor is off");
  a_req_stable: assert property (o_sens_req && !i_sens_done |=> o_sens_req &&
    $stable({o_sens_we, o_sens_addr, o_sens_wdata}))
    else $error("sensor request changed before done");
  a_req_ends: assert property (o_sens_req && i_sens_done |=> !o_sens_req)
    else $error("sensor request not dropped after done");
  a_off_in_reset: assert property (!o_sens_pwr_en |-> !o_sens_rst_b)
    else $error("sensor unpowered but out of reset");
  a_power_first: assert property ($rose(o_sens_pwr_en) |-> s_settle ##1 s_release)
    else $error("sensor reset released out of order");
  a_off_length: assert property ($rose(o_sens_pwr_en) |-> off_cnt_reg >= SENS_OFF_CYC)
    else $error("sensor off time too short");
  a_restart_off: assert property ($rose(o_module_restart) |->
    ##[0:2] (!o_sens_pwr_en && !o_sens_rst_b))
    else $error("module restart did not reset sensor");
  a_roi_limit: assert property ($past(i_rst_b) |->
    o_roi_max == ($past(i_global_shutter) ? 4'h8 : 4'h1))
    else $error("window count wrong");
  a_stretch_bound: assert property ($rose(o_scl_oe) |-> ##[1:1000] !o_scl_oe)
    else $error("clock stretch too long");
endmodule

bind cbr_ctrl_status cbr_ctrl_status_monitor #(.SENS_OFF_CYC(SENS_OFF_CYC)) mon (
  .i_sys_clk, .i_rst_b, .o_scl_oe, .o_sens_req, .o_sens_we, .o_sens_addr, .o_sens_wdata,
  .i_sens_done, .o_sens_pwr_en, .o_sens_rst_b, .o_module_restart, .i_global_shutter,
  .o_roi_max);

//--- cbr_host_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Two-wire host master with pull-ups
// ****************************************************************
module cbr_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_scl_oe,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  logic stuck   = 1'b0;

  // A released line is pulled high.
  assign o_scl = !(scl_low || i_scl_oe);
  assign o_sda = !(sda_low || i_sda_oe);

  task automatic hc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic bit_io(input logic b, output logic r);
    int n;
    n = 0;
    sda_low = !b;
    hc(4);
    scl_low = 1'b0;
    // The device may stretch the clock low.
    while (!o_scl && n < 2000) begin
      hc(1);
      n++;
    end
    if (n == 2000) begin
      stuck = 1'b1;
    end
    hc(4);
    r = o_sda;
    scl_low = 1'b1;
    hc(1);
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q,
                         output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ai, ak);
  endtask

  task automatic start_c;
    sda_low = 1'b0;
    hc(2);
    scl_low = 1'b0;
    hc(4);
    sda_low = 1'b1;
    hc(4);
    scl_low = 1'b1;
    hc(2);
  endtask

  task automatic xfer(input logic [7:0] ra, input logic rd, input logic [15:0] wd,
                      output logic [15:0] rv, output logic ok);
    logic [7:0] q;
    logic [3:0] a;
    start_c;
    byte_io(8'h90, 1'b1, q, a[0]);
    byte_io(ra, 1'b1, q, a[1]);
    if (rd) begin
      start_c;
      byte_io(8'h91, 1'b1, q, a[2]);
      byte_io(8'hff, 1'b0, rv[15:8], a[3]);
      byte_io(8'hff, 1'b1, rv[7:0], a[3]);
      a[3] = 1'b0;
    end else begin
      byte_io(wd[15:8], 1'b1, q, a[2]);
      byte_io(wd[7:0], 1'b1, q, a[3]);
    end
    ok = (a === 4'h0) && !stuck;
    sda_low = 1'b1;
    hc(2);
    scl_low = 1'b0;
    hc(4);
    sda_low = 1'b0;
    hc(4);
  endtask
endmodule

//--- camera_bridge_control_status_bench.sv
`timescale 1ns/10ps

`define CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end

module camera_bridge_control_status_bench;
  localparam int unsigned OFF_CYC = 3000;
  localparam int          DLY     = 700;
  localparam logic [15:0] FW_ID   = 16'h0a3c; // Value is arbitrary.

  logic        i_sys_clk, i_rst_b, i_sens_done, i_global_shutter, scl, sda, ok;
  logic        o_scl_oe, o_sda_oe, o_sens_req, o_sens_we, cap_we;
  logic        o_sens_pwr_en, o_sens_rst_b, o_module_restart;
  logic [8:0]  o_sens_addr, cap_addr;
  logic [15:0] o_sens_wdata, i_sens_rdata, cap_wdata, rd_val;
  logic [3:0]  o_roi_max;
  logic        scl_drv, sda_drv;
  int          failures, n_compared, cyc, sdly, off_len, off_cnt;

  cbr_ctrl_status #(.SENS_OFF_CYC(OFF_CYC), .RESTART_CYC(OFF_CYC), .FIRMWARE_ID(FW_ID)) uut (
    .i_sys_clk, .i_rst_b, .i_scl(scl), .o_scl(scl_drv), .o_scl_oe,
    .i_sda(sda), .o_sda(sda_drv), .o_sda_oe,
    .o_sens_req, .o_sens_we, .o_sens_addr, .o_sens_wdata, .i_sens_done, .i_sens_rdata,
    .o_sens_pwr_en, .o_sens_rst_b, .o_module_restart, .i_global_shutter, .o_roi_max);

  cbr_host_model host (.i_sys_clk, .i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe), .o_scl(scl),
                       .o_sda(sda));

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // ****************************************************************
  // Slow sensor engine and sensor off-time meter
  // ****************************************************************
  always @(posedge i_sys_clk) begin
    #1;
    i_sens_done = 1'b0;
    i_sens_rdata = ~i_sens_rdata;
    if (!o_sens_pwr_en) begin
      off_cnt++;
    end else if (off_cnt != 0) begin
      off_len = off_cnt;
      off_cnt = 0;
    end
    if (o_sens_req) begin
      sdly++;
      if (sdly == DLY) begin
        sdly = 0;
        i_sens_done = 1'b1;
        i_sens_rdata = {7'h08, o_sens_addr};
        cap_addr = o_sens_addr;
        cap_we = o_sens_we;
        cap_wdata = o_sens_wdata;
      end
    end
  end

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      stop_test;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic wr16(input logic [7:0] ra, input logic [15:0] d);
    host.xfer(ra, 1'b0, d, rd_val, ok);
    `CHECK("write ack", 1'b1, ok)
  endtask

  task automatic rd16(input logic [7:0] ra, input logic [15:0] exp, input string nm);
    host.xfer(ra, 1'b1, 16'h0000, rd_val, ok);
    `CHECK("read ack", 1'b1, ok)
    `CHECK(nm, exp, rd_val)
  endtask

  task automatic wait_up;
    int n;
    n = 0;
    while (o_sens_rst_b !== 1'b1 && n < 20000) begin
      tick(1);
      n++;
    end
    `CHECK("sensor up", 1'b1, o_sens_rst_b)
  endtask

  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    i_rst_b = 1'b0;
    i_sens_done = 1'b0;
    i_sens_rdata = 16'h0000;
    i_global_shutter = 1'b0;
    tick(12);
    i_rst_b = 1'b1;
    tick(2);
    rd16(8'h98, 16'h0000, "control");
    rd16(8'h97, FW_ID, "firmware");
    `CHECK("scl drive", 1'b0, scl_drv)
    `CHECK("sda drive", 1'b0, sda_drv)
    wr16(8'h99, 16'hffff);
    rd16(8'h99, 16'h0000, "status");
    $display("test reset finished");
    wr16(8'h98, 16'h0001);
    wr16(8'h12, 16'hbeef);
    rd16(8'h99, 16'h0002, "write busy");
    rd16(8'h98, 16'h0001, "control busy");
    tick(DLY);
    rd16(8'h99, 16'h0000, "write idle");
    `CHECK("sensor address", 9'h112, cap_addr)
    `CHECK("sensor data", 16'hbeef, cap_wdata)
    `CHECK("sensor write", 1'b1, cap_we)
    wr16(8'h98, 16'h0000);
    rd16(8'h34, 16'h1034, "sensor read");
    `CHECK("sensor address", 9'h034, cap_addr)
    `CHECK("sensor read", 1'b0, cap_we)
    rd16(8'h99, 16'h0000, "read idle");
    $display("test paging finished");
    wr16(8'h98, 16'h0003);
    wr16(8'h98, 16'h0001);
    rd16(8'h98, 16'h0003, "timed running");
    `CHECK("sensor power", 1'b0, o_sens_pwr_en)
    wait_up;
    `CHECK("off time", OFF_CYC, off_len)
    rd16(8'h98, 16'h0001, "timed done");
    $display("test timed finished");
    wr16(8'h98, 16'hfef5);
    rd16(8'h98, 16'h0005, "held");
    tick(2 * OFF_CYC);
    `CHECK("held power", 1'b0, o_sens_pwr_en)
    wr16(8'h98, 16'h0001);
    wait_up;
    `CHECK("sensor power", 1'b1, o_sens_pwr_en)
    $display("test held finished");
    wr16(8'h98, 16'h0101);
    `CHECK("restart", 1'b1, o_module_restart)
    wait_up;
    rd16(8'h98, 16'h0000, "after restart");
    $display("test restart finished");
    i_global_shutter = 1'b1;
    tick(2);
    `CHECK("windows", 4'h8, o_roi_max)
    i_global_shutter = 1'b0;
    tick(2);
    `CHECK("windows", 4'h1, o_roi_max)
    $display("test windows finished");
    stop_test;
  end
endmodule
